// ===== hlcr_pkg.sv
`default_nettype none
// Shared constants of the host link id, retry and swap register bank
package hlcr_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_VERSION = 8'h00;
	localparam logic [7:0] OFF_ROM     = 8'h04;
	localparam logic [7:0] OFF_RETRY   = 8'h08;
	localparam logic [7:0] OFF_SDATA   = 8'h0C;
	localparam logic [7:0] OFF_SCMP    = 8'h10;
	localparam logic [7:0] OFF_SCTRL   = 8'h14;
	// Version word fields
	localparam int         VER_PRESENT_BIT = 24;
	localparam logic [7:0] VER_MAJOR       = 8'h01;
	localparam logic [7:0] VER_MINOR       = 8'h00;
	// ROM access word fields
	localparam int ROM_CLEAR_BIT = 31;
	localparam int ROM_GO_BIT    = 25;
	// Retry field positions
	localparam int RTY_PHYS_LSB = 8;
	localparam int RTY_RESP_LSB = 4;
	localparam int RTY_REQ_LSB  = 0;
	localparam logic [3:0] RTY_RESET = 4'h0;
	// Swap control fields and reset
	localparam int   SCTRL_DONE_BIT   = 31;
	localparam logic SCTRL_DONE_RESET = 1'b1;
	// Swap target codes
	localparam logic [1:0] SEL_BUS_MGR  = 2'h0;
	localparam logic [1:0] SEL_BANDW    = 2'h1;
	localparam logic [1:0] SEL_CHAN_HI  = 2'h2;
	localparam logic [1:0] SEL_CHAN_LO  = 2'h3;
	// Reset contents of the four bus management resources
	localparam logic [31:0] RES_BUS_MGR_RESET = 32'h0000003F;
	localparam logic [31:0] RES_BANDW_RESET   = 32'h00001333;
	localparam logic [31:0] RES_CHAN_RESET    = 32'hFFFFFFFF;
	// Cycles spent waiting for the synchronised ROM detect to settle
	localparam logic [1:0] BOOT_CYCLES = 2'h3;
endpackage
`default_nettype wire

// ===== hlcr_regs.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Version bit 24 shows attached ROM
// - ROM present: bus info loads after reset
// - Version major field reads 01
// - Version minor field reads 00
// - Address clear bit zeroes address, self-clears
// - Address clear fetches no byte
// - Read go fetches addressed byte, self-clears
// - Last fetched byte shown in bits 23:16
// - Second limit field reads zero
// - Cycle limit field reads zero
// - Physical response retry count bits 11:8
// - Async response retry count bits 7:4
// - Async request retry count bits 3:0
// - Swap data stored on successful compare
// - Swap compare tested against resource
// - Control write starts swap on selected resource
// - Done flag sets at finish, write clears
// - Select codes pick four bus resources
module hlcr_regs (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        reg_wr_en,
	input  wire logic        reg_rd_en,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	output logic      [31:0] reg_rdata,
	input  wire logic        rom_detect,
	output logic             rom_rd_req,
	output logic      [7:0]  rom_rd_addr,
	input  wire logic        rom_rd_ack,
	input  wire logic [7:0]  rom_rd_data,
	output logic             rom_load_req,
	input  wire logic        rom_load_done,
	output logic      [3:0]  phys_response_retry_max,
	output logic      [3:0]  async_response_retry_max,
	output logic      [3:0]  async_request_retry_max
);
	// One-hot sequencer states
	typedef enum logic [3:0] {
		ST_BOOT = 4'h1,
		ST_LOAD = 4'h2,
		ST_IDLE = 4'h4,
		ST_READ = 4'h8
	} hlcr_state_e;

	typedef struct packed {
		hlcr_state_e st;         // ROM sequencer state
		logic [1:0]  boot_cnt;   // Settle count after reset
		logic        load_req;   // Bus info autoload request
		logic [31:0] rdata;      // Read data, held until next read
		logic        addr_clear; // Software address clear request
		logic        read_go;    // Software byte read request
		logic        rd_req;     // Byte fetch toward ROM engine
		logic [7:0]  rom_addr;   // Current ROM byte address
		logic [7:0]  read_byte;  // Last byte fetched
		logic [3:0]  phys_max;   // Physical response retries
		logic [3:0]  resp_max;   // Async response retries
		logic [3:0]  req_max;    // Async request retries
		logic [31:0] swap_data;  // New value, later the prior value
		logic [31:0] swap_cmp;   // Compare value
		logic [1:0]  swap_sel;   // Target resource code
		logic        swap_done;  // Completion flag
		logic        swap_start; // One cycle start pulse
	} hlcr_regs_s;

	hlcr_regs_s r_r;
	hlcr_regs_s r_nxt;
	logic       present;   // Synchronised ROM detect level
	logic       swap_fin;  // Swap unit completion pulse
	logic [31:0] swap_old; // Prior resource value
	logic [31:0] rd_word;  // Addressed register contents

	// ROM detect comes from a pin, so it is synchronised first
	hlcr_sync2 u_sync (
		.clk     (clk),
		.reset_n (reset_n),
		.d       (rom_detect),
		.q       (present)
	);

	// Resource store and atomic compare-swap
	hlcr_swap_unit u_swap (
		.clk     (clk),
		.reset_n (reset_n),
		.start   (r_r.swap_start),
		.sel     (r_r.swap_sel),
		.cmp_val (r_r.swap_cmp),
		.new_val (r_r.swap_data),
		.done    (swap_fin),
		.old_val (swap_old)
	);

	// Read multiplexer; unmapped offsets read zero
	always_comb
	begin
		case (reg_addr)
			hlcr_pkg::OFF_VERSION:
				rd_word = {7'h00, present, hlcr_pkg::VER_MAJOR, 8'h00,
					hlcr_pkg::VER_MINOR};
			hlcr_pkg::OFF_ROM:
				rd_word = {r_r.addr_clear, 5'h00, r_r.read_go, 1'b0,
					r_r.read_byte, 16'h0000};
			hlcr_pkg::OFF_RETRY:
				rd_word = {3'h0, 13'h0000, 4'h0, r_r.phys_max,
					r_r.resp_max, r_r.req_max};
			hlcr_pkg::OFF_SDATA:
				rd_word = r_r.swap_data;
			hlcr_pkg::OFF_SCMP:
				rd_word = r_r.swap_cmp;
			hlcr_pkg::OFF_SCTRL:
				rd_word = {r_r.swap_done, 29'h00000000, r_r.swap_sel};
			default:
				rd_word = 32'h00000000;
		endcase
	end

	// Next state: sequencer first, then bus writes, then swap return,
	// so a hardware set always beats a clear in the same cycle
	always_comb
	begin
		r_nxt = r_r;
		r_nxt.swap_start = 1'b0;
		if (reg_rd_en)
			r_nxt.rdata = rd_word;
		case (r_r.st)
			ST_BOOT:
			begin
				// Wait for the synchronised detect before deciding
				if (r_r.boot_cnt == hlcr_pkg::BOOT_CYCLES)
				begin
					r_nxt.load_req = present;
					r_nxt.st = present ? ST_LOAD : ST_IDLE;
				end
				else
					r_nxt.boot_cnt = r_r.boot_cnt + 2'h1;
			end
			ST_LOAD:
			begin
				// Byte reads wait until the autoload has finished
				if (rom_load_done)
				begin
					r_nxt.load_req = 1'b0;
					r_nxt.st = ST_IDLE;
				end
			end
			ST_IDLE:
			begin
				if (r_r.addr_clear)
				begin
					// Address only; the read byte stays as it was
					r_nxt.rom_addr = 8'h00;
					r_nxt.addr_clear = 1'b0;
				end
				else if (r_r.read_go)
				begin
					// With no ROM the engine never answers; software avoids this
					r_nxt.rd_req = 1'b1;
					r_nxt.st = ST_READ;
				end
			end
			ST_READ:
			begin
				if (rom_rd_ack)
				begin
					r_nxt.read_byte = rom_rd_data;
					r_nxt.rom_addr = r_r.rom_addr + 8'h01;
					r_nxt.read_go = 1'b0;
					r_nxt.rd_req = 1'b0;
					r_nxt.st = ST_IDLE;
				end
			end
			default:
				r_nxt.st = ST_IDLE;
		endcase
		if (reg_wr_en)
		begin
			case (reg_addr)
				hlcr_pkg::OFF_ROM:
				begin
					// Writing zero leaves a pending request alone
					if (reg_wdata[hlcr_pkg::ROM_CLEAR_BIT])
						r_nxt.addr_clear = 1'b1;
					if (reg_wdata[hlcr_pkg::ROM_GO_BIT])
						r_nxt.read_go = 1'b1;
				end
				hlcr_pkg::OFF_RETRY:
				begin
					r_nxt.phys_max = reg_wdata[hlcr_pkg::RTY_PHYS_LSB +: 4];
					r_nxt.resp_max = reg_wdata[hlcr_pkg::RTY_RESP_LSB +: 4];
					r_nxt.req_max = reg_wdata[hlcr_pkg::RTY_REQ_LSB +: 4];
				end
				hlcr_pkg::OFF_SDATA:
					r_nxt.swap_data = reg_wdata;
				hlcr_pkg::OFF_SCMP:
					r_nxt.swap_cmp = reg_wdata;
				hlcr_pkg::OFF_SCTRL:
				begin
					r_nxt.swap_sel = reg_wdata[1:0];
					r_nxt.swap_done = 1'b0;
					r_nxt.swap_start = 1'b1;
				end
				default:
				begin
					// Version and unmapped offsets ignore writes
					r_nxt.swap_start = 1'b0;
				end
			endcase
		end
		if (swap_fin)
		begin
			r_nxt.swap_data = swap_old;
			r_nxt.swap_done = 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			r_r <= '0;
			r_r.st <= ST_BOOT;
			r_r.phys_max <= hlcr_pkg::RTY_RESET;
			r_r.resp_max <= hlcr_pkg::RTY_RESET;
			r_r.req_max <= hlcr_pkg::RTY_RESET;
			r_r.swap_done <= hlcr_pkg::SCTRL_DONE_RESET;
		end
		else
			r_r <= r_nxt;
	end

	// Outputs straight from the state flops
	assign reg_rdata = r_r.rdata;
	assign rom_rd_req = r_r.rd_req;
	assign rom_rd_addr = r_r.rom_addr;
	assign rom_load_req = r_r.load_req;
	assign phys_response_retry_max = r_r.phys_max;
	assign async_response_retry_max = r_r.resp_max;
	assign async_request_retry_max = r_r.req_max;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	// Bus access shapes shared by several checks
	sequence ver_read_s;
		reg_rd_en && reg_addr == hlcr_pkg::OFF_VERSION;
	endsequence
	sequence sctrl_write_s;
		reg_wr_en && reg_addr == hlcr_pkg::OFF_SCTRL;
	endsequence

	// Version fields are constants whatever was written
	version_major_a: assert property (
		ver_read_s |=> reg_rdata[23:16] == 8'h01)
		else $error("major version not 01");
	version_minor_a: assert property (
		ver_read_s |=> reg_rdata[7:0] == 8'h00 && reg_rdata[15:8] == 8'h00)
		else $error("minor version not 00");
	// Present flag shows the synchronised detect seen at the read edge
	rom_flag_a: assert property (
		ver_read_s |=> reg_rdata[24] == $past(present))
		else $error("ROM flag does not follow detect");
	// End of boot with a ROM attached goes straight to the autoload
	autoload_a: assert property (
		r_r.st == ST_BOOT && r_r.boot_cnt == hlcr_pkg::BOOT_CYCLES && present
		|=> rom_load_req throughout (##[0:2] r_r.st == ST_LOAD))
		else $error("autoload not requested");
	// Clearing the address never fetches a byte
	addr_clear_a: assert property (
		r_r.st == ST_IDLE && r_r.addr_clear && !reg_wr_en
		|=> rom_rd_addr == 8'h00 && !r_r.addr_clear && $stable(r_r.read_byte))
		else $error("address clear misbehaved");
	// An answered fetch lands the byte and steps the address
	byte_fetch_a: assert property (
		r_r.st == ST_READ && rom_rd_ack
		|=> r_r.read_byte == $past(rom_rd_data) && !rom_rd_req
			&& rom_rd_addr == $past(rom_rd_addr) + 8'h01)
		else $error("byte fetch did not complete");
	// Engine may answer at once, so only the launch itself is checked here
	read_start_a: assert property (
		r_r.st == ST_IDLE && r_r.read_go && !r_r.addr_clear
		|=> rom_rd_req && r_r.st == ST_READ)
		else $error("read go did not start fetch");
	// A pending fetch holds request and address until the engine answers
	fetch_hold_a: assert property (
		rom_rd_req && !rom_rd_ack |=> rom_rd_req && $stable(rom_rd_addr))
		else $error("fetch request dropped early");
	// The autoload request stays up until the load reports done
	load_hold_a: assert property (
		rom_load_req && !rom_load_done |=> rom_load_req)
		else $error("autoload request dropped early");
	// Dual phase fields are not built and always read zero
	retry_high_a: assert property (
		reg_rd_en && reg_addr == hlcr_pkg::OFF_RETRY |=> reg_rdata[31:12] == 20'h00000)
		else $error("retry high fields not zero");
	// Retry limits leave the bank on the cycle after the write
	retry_copy_a: assert property (
		reg_wr_en && reg_addr == hlcr_pkg::OFF_RETRY
		|=> {phys_response_retry_max, async_response_retry_max, async_request_retry_max}
			== $past(reg_wdata[11:0]))
		else $error("retry limits not copied");
	// A control write launches the swap on the code just written
	swap_launch_a: assert property (
		sctrl_write_s |=> r_r.swap_start && r_r.swap_sel == $past(reg_wdata[1:0]))
		else $error("control write did not launch swap");
	// Flag clears on the write and sets two cycles after the launch
	swap_clear_a: assert property (
		(sctrl_write_s and !swap_fin)
		|=> !r_r.swap_done ##1 !r_r.swap_done ##1 r_r.swap_done)
		else $error("swap done flag timing wrong");
endmodule
`default_nettype wire

// ===== hlcr_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module hlcr_regs_tb;
	logic        clk;
	logic        reset_n;
	logic        reg_wr_en;
	logic        reg_rd_en;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic [31:0] reg_rdata;
	logic        rom_detect;
	logic        rom_rd_req;
	logic [7:0]  rom_rd_addr;
	logic        rom_rd_ack;
	logic [7:0]  rom_rd_data;
	logic        rom_load_req;
	logic        rom_load_done;
	logic        slow;       // Model answers late when set
	logic [3:0]  phys_max;
	logic [3:0]  resp_max;
	logic [3:0]  req_max;
	logic [31:0] seed;       // Xorshift state
	logic [31:0] res [4];    // Expected bus resources
	logic [31:0] d;
	logic [31:0] v;
	logic [31:0] c;
	logic [31:0] nv;
	logic [1:0]  s;
	int          i;
	int          bad_count;
	int          n_tests;

	hlcr_regs dut (.clk(clk), .reset_n(reset_n), .reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .rom_detect(rom_detect), .rom_rd_req(rom_rd_req),
		.rom_rd_addr(rom_rd_addr), .rom_rd_ack(rom_rd_ack), .rom_rd_data(rom_rd_data),
		.rom_load_req(rom_load_req), .rom_load_done(rom_load_done),
		.phys_response_retry_max(phys_max), .async_response_retry_max(resp_max),
		.async_request_retry_max(req_max));
	hlcr_rom_model rom (.clk(clk), .slow(slow), .rom_rd_req(rom_rd_req),
		.rom_rd_addr(rom_rd_addr), .rom_rd_ack(rom_rd_ack), .rom_rd_data(rom_rd_data),
		.rom_load_req(rom_load_req), .rom_load_done(rom_load_done));

	// 200 MHz clock
	always #2.5 clk = ~clk;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Byte the ROM model holds at an address
	function automatic logic [7:0] rom_byte(input logic [7:0] a);
		return a ^ 8'hC3;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// One write; strobe lowered a full cycle later so tasks never collide
	task automatic wr(input logic [7:0] a, input logic [31:0] dt);
		@(negedge clk);
		reg_wr_en = 1'b1;
		reg_addr  = a;
		reg_wdata = dt;
		@(negedge clk);
		reg_wr_en = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] dt);
		@(negedge clk);
		reg_rd_en = 1'b1;
		reg_addr  = a;
		@(negedge clk);
		reg_rd_en = 1'b0;
		dt        = reg_rdata;
	endtask
	// Read until masked bits equal want; a stuck bit ends the run
	task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] want,
		output logic [31:0] dt);
		for (int k = 0; k < 40; k++)
		begin
			rd(a, dt);
			if ((dt & m) === want)
				return;
		end
		bad_count++;
		report_and_stop();
	endtask
	task automatic do_reset(input logic det);
		reset_n    = 1'b0;
		rom_detect = det;
		repeat (20) @(negedge clk);
		reset_n = 1'b1;
	endtask

	initial
	begin
		clk       = 1'b0;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr  = 8'h00;
		reg_wdata = 32'h0;
		slow      = 1'b0;
		seed      = 32'h29CB469A;
		bad_count = 0;
		n_tests   = 0;
		res[0]    = hlcr_pkg::RES_BUS_MGR_RESET;
		res[1]    = hlcr_pkg::RES_BANDW_RESET;
		res[2]    = hlcr_pkg::RES_CHAN_RESET;
		res[3]    = hlcr_pkg::RES_CHAN_RESET;
		do_reset(1'b0);
		// Version word with no ROM; writes must not stick
		rd(hlcr_pkg::OFF_VERSION, d);
		chk(d, 32'h0001_0000);
		wr(hlcr_pkg::OFF_VERSION, rnd());
		rd(hlcr_pkg::OFF_VERSION, d);
		chk(d, 32'h0001_0000);
		chk({31'h0, rom_load_req}, 32'h0);
		rd(8'h18, d);
		chk(d, 32'h0);
		$display("version test done");
		// Retry limits: dual phase fields stay zero
		rd(hlcr_pkg::OFF_RETRY, d);
		chk(d, 32'h0);
		wr(hlcr_pkg::OFF_RETRY, 32'hFFFF_FFFF);
		rd(hlcr_pkg::OFF_RETRY, d);
		chk(d, 32'h0000_0FFF);
		repeat (6)
		begin
			v = rnd();
			wr(hlcr_pkg::OFF_RETRY, v);
			rd(hlcr_pkg::OFF_RETRY, d);
			chk(d, v & 32'h0000_0FFF);
			chk({20'h0, phys_max, resp_max, req_max}, v & 32'h0000_0FFF);
		end
		$display("retry test done");
		// Compare-swap on every target; first pass misses, second pass matches
		rd(hlcr_pkg::OFF_SCTRL, d);
		chk(d & 32'h8000_0000, 32'h8000_0000);
		for (i = 0; i < 8; i++)
		begin
			v  = rnd();
			s  = i[1:0];
			nv = rnd();
			c  = i[2] ? res[s] : v;
			wr(hlcr_pkg::OFF_SDATA, nv);
			wr(hlcr_pkg::OFF_SCMP, c);
			wr(hlcr_pkg::OFF_SCTRL, {30'h0, s});
			// First read lands while the swap is still under way
			rd(hlcr_pkg::OFF_SCTRL, d);
			chk(d & 32'h8000_0000, 32'h0);
			poll(hlcr_pkg::OFF_SCTRL, 32'h8000_0000, 32'h8000_0000, d);
			chk(d, {1'b1, 29'h0, s});
			rd(hlcr_pkg::OFF_SDATA, d);
			chk(d, res[s]);
			rd(hlcr_pkg::OFF_SCMP, d);
			chk(d, c);
			if (c === res[s])
				res[s] = nv;
		end
		$display("swap test done");
		// ROM attached: autoload, then byte reads; port used only now
		do_reset(1'b1);
		for (i = 0; i < 40 && rom_load_req !== 1'b1; i++)
			@(negedge clk);
		chk({31'h0, rom_load_req}, 32'h1);
		if (rom_load_req !== 1'b1)
			report_and_stop();
		rd(hlcr_pkg::OFF_VERSION, d);
		chk(d, 32'h0101_0000);
		for (i = 0; i < 2; i++)
		begin
			slow = i[0];
			wr(hlcr_pkg::OFF_ROM, 32'h0200_0000);
			poll(hlcr_pkg::OFF_ROM, 32'h0200_0000, 32'h0, d);
			chk(d, {8'h0, rom_byte(i[7:0]), 16'h0});
		end
		wr(hlcr_pkg::OFF_ROM, 32'h8000_0000);
		poll(hlcr_pkg::OFF_ROM, 32'h8000_0000, 32'h0, d);
		chk(d, {8'h0, rom_byte(8'h01), 16'h0});
		chk({24'h0, rom_rd_addr}, 32'h0);
		wr(hlcr_pkg::OFF_ROM, 32'h8200_0000);
		poll(hlcr_pkg::OFF_ROM, 32'h8200_0000, 32'h0, d);
		chk(d, {8'h0, rom_byte(8'h00), 16'h0});
		chk({24'h0, rom_rd_addr}, 32'h1);
		$display("rom test done");
		report_and_stop();
	end
endmodule
`default_nettype wire

// ===== hlcr_rom_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural ROM engine seen from the register bank
module hlcr_rom_model (
	input  wire logic       clk,
	input  wire logic       slow,
	input  wire logic       rom_rd_req,
	input  wire logic [7:0] rom_rd_addr,
	output logic            rom_rd_ack,
	output logic      [7:0] rom_rd_data,
	input  wire logic       rom_load_req,
	output logic            rom_load_done
);
	int rd_cnt;   // Cycles the current fetch has waited
	int ld_cnt;   // Cycles the autoload has run
	initial
	begin
		rom_rd_ack    = 1'b0;
		rom_rd_data   = 8'h00;
		rom_load_done = 1'b0;
		rd_cnt        = 0;
		ld_cnt        = 0;
	end
	// Fetch answered after 3 or 10 cycles; data flips when not valid,
	// so a bank that samples outside the ack pulse reads garbage
	always @(negedge clk)
	begin
		rom_rd_ack  <= 1'b0;
		rom_rd_data <= ~rom_rd_data;
		if (rom_rd_req && !rom_rd_ack)
		begin
			rd_cnt <= rd_cnt + 1;
			if (rd_cnt >= (slow ? 9 : 2))
			begin
				rom_rd_ack  <= 1'b1;
				rom_rd_data <= rom_rd_addr ^ 8'hC3;
				rd_cnt      <= 0;
			end
		end
	end
	// Autoload ends with one pulse a few cycles after the request
	always @(negedge clk)
	begin
		rom_load_done <= 1'b0;
		ld_cnt        <= rom_load_req ? ld_cnt + 1 : 0;
		if (rom_load_req && ld_cnt == 6)
			rom_load_done <= 1'b1;
	end
endmodule
`default_nettype wire

// ===== hlcr_swap_unit.sv
`timescale 1ns/1ps
`default_nettype none
// Holds the four bus management resources and runs compare-swap
module hlcr_swap_unit (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        start,
	input  wire logic [1:0]  sel,
	input  wire logic [31:0] cmp_val,
	input  wire logic [31:0] new_val,
	output logic             done,
	output logic [31:0]      old_val
);
	typedef struct packed {
		logic [3:0][31:0] res;  // Resources indexed by target code
		logic             done; // One cycle completion pulse
		logic [31:0]      old;  // Value seen before the swap
	} hlcr_swap_s;

	hlcr_swap_s r_r;
	hlcr_swap_s r_nxt;

	// Compare and replace in one cycle, so no other access can interleave
	always_comb
	begin
		r_nxt = r_r;
		r_nxt.done = 1'b0;
		if (start)
		begin
			r_nxt.old = r_r.res[sel];
			r_nxt.done = 1'b1;
			if (r_r.res[sel] == cmp_val)
				r_nxt.res[sel] = new_val;
		end
	end

	// State register
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			r_r <= '0;
			r_r.res[hlcr_pkg::SEL_BUS_MGR] <= hlcr_pkg::RES_BUS_MGR_RESET;
			r_r.res[hlcr_pkg::SEL_BANDW] <= hlcr_pkg::RES_BANDW_RESET;
			r_r.res[hlcr_pkg::SEL_CHAN_HI] <= hlcr_pkg::RES_CHAN_RESET;
			r_r.res[hlcr_pkg::SEL_CHAN_LO] <= hlcr_pkg::RES_CHAN_RESET;
		end
		else
			r_r <= r_nxt;
	end

	assign done = r_r.done;
	assign old_val = r_r.old;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	// A matching compare leaves the new value in the target
	swap_hit_a: assert property (
		start && r_r.res[sel] == cmp_val |=> r_r.res[$past(sel)] == $past(new_val))
		else $error("swap did not store new value on match");
	// A miss leaves the target untouched and returns the old value
	swap_miss_a: assert property (
		start && r_r.res[sel] != cmp_val |=> done && old_val == r_r.res[$past(sel)])
		else $error("swap miss changed target or lost old value");
endmodule
`default_nettype wire

// ===== hlcr_sync2.sv
`timescale 1ns/1ps
`default_nettype none
// Two flop synchroniser for a level from a pin
module hlcr_sync2 (
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic d,
	output logic      q
);
	typedef struct packed {
		logic s1; // Metastable stage, read only by s2
		logic s2; // Settled stage
	} hlcr_sync_s;

	hlcr_sync_s r_r;
	hlcr_sync_s r_nxt;

	// Shift the pin level through both stages
	always_comb
	begin
		r_nxt = r_r;
		r_nxt.s1 = d;
		r_nxt.s2 = r_r.s1;
	end

	// State register
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			r_r <= '0;
		else
			r_r <= r_nxt;
	end

	assign q = r_r.s2;
endmodule
`default_nettype wire
